/* File: design/sadd_pkg.sv */
// Package for the subtractive adder datapath: widths, masks, reset values,
// load selects and the control and source carriers.
// Assumes the instruction control section drives every select on sys_clk.
package sadd_pkg;

   // Adder geometry: 24 stages in four groups of six.
   localparam int unsigned WORD_W = 24;
   localparam int unsigned GRP_W = 6;
   localparam int unsigned GRP_N = 4;
   localparam int unsigned ADDR_W = 14;
   localparam int unsigned TALLY_LSB = 14;

   // Reset values.
   localparam logic [23:0] WORD_RST = 24'h000000;
   localparam logic [13:0] PC_RST = 14'h0000;

   // Addend constants and field masks.
   localparam logic [23:0] PLUS_ONE = 24'h000001;
   localparam logic [23:0] PLUS_TWO = 24'h000002;
   localparam logic [23:0] UPD_ADDEND = 24'hFFC000;
   localparam logic [23:0] FORCE_MASK = 24'h004000;
   localparam logic [23:0] LOW14_MASK = 24'h003FFF;
   localparam logic [23:0] ADDR9_MASK = 24'h0001FF;

   // Operand register load sources.
   typedef enum logic [2:0] {XS_HOLD, XS_MEM, XS_ACC, XS_PC, XS_IDX, XS_BASE} sadd_xsel_t;

   // Addend register load sources.
   typedef enum logic [2:0] {
      DS_HOLD, DS_X, DS_XN, DS_ACCN, DS_X9, DS_P1, DS_P2, DS_UPD
   } sadd_dsel_t;

   // Accumulator and lower-rank load sources.
   typedef enum logic [2:0] {AS_HOLD, AS_CLR, AS_LOG, AS_ALG, AS_U} sadd_asel_t;
   typedef enum logic [1:0] {US_HOLD, US_SHL, US_SHR} sadd_usel_t;

   // Word-updating modes that steer forced and inhibited borrows.
   typedef enum logic [1:0] {UP_NONE, UP_CW, UP_ADV, UP_REP} sadd_upd_t;

   typedef struct packed {
      sadd_xsel_t x_sel;
      sadd_dsel_t d_sel;
      sadd_asel_t a_sel;
      sadd_usel_t u_sel;
      sadd_upd_t upd_mode;
      logic pc_load;
      logic sel_load;
   } sadd_ctrl_t;

   typedef struct packed {
      logic [23:0] mem_word;
      logic [23:0] idx_word;
      logic [13:0] base_word;
      logic shift_in;
   } sadd_src_t;

endpackage

/* File: design/sadd_datapath.sv */
// Subtractive adder datapath: operand, addend, accumulator, lower-rank,
// program counter and selector word registers around a 24-bit adder.
// Assumes a control section on sys_clk sequences every load select.
//
// How it works
// - Result bit is half-subtract xor lower borrow.
// - Group bypass enable when group half-subtract zero and no forced borrow.
// - Borrow skips unable groups, wraps end-around.
// - Bypassed group result bits come out inverted.
// - Accumulator loads logical or algebraic difference.
// - Shifts go through lower rank, then back.
// - Control word: count down, address up.
// - Tally-and-advance: tally down, address up.
// - Tally-and-repeat: tally down, address kept.
// - Word update forces addend upper ten bits.
// - Forced borrow into stage 14 during update.
// - End-around borrow suppressed for count updates.
// - Repeat update forces end-around borrow too.
// - Program counter advanced by one or two.
// - Index modification sums address and index.
// - Base modification sums base and 9-bit address.
// - Add-one sum goes to the selector word.
// - Twenty-four stages in four groups of six.
// - Adder always subtracts complemented addend.
// - Half-subtract is operand xor complemented addend.
`timescale 1ns/1ps

module sadd_datapath (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic reset_n,
   // Control section requests and source words.
   input wire sadd_pkg::sadd_ctrl_t ctrl,
   input wire sadd_pkg::sadd_src_t src,
   // Results.
   output logic [23:0] acc_word,
   output logic [23:0] low_rank_word,
   output logic [13:0] pc_word,
   output logic [23:0] sel_word,
   output logic tally_zero
);

   logic [23:0] x_q;
   logic [23:0] d_q;
   logic [23:0] a_q;
   logic [23:0] u_q;
   logic [13:0] pc_q;
   logic [23:0] sel_q;

   logic [23:0] dn;
   logic [23:0] half;
   logic [23:0] full;
   logic [23:0] inj;
   logic [3:0] grp_gen;
   logic [3:0] grp_byp_en;
   logic [3:0] grp_cin;
   logic [3:0] grp_skip;
   logic force14;
   logic inhibit_ea;
   logic force_ea;
   logic end_borrow;

   // Ripple borrows through one six-stage group; inj ORs a borrow into a stage.
   function automatic logic [5:0] sadd_grp_borrow(input logic [5:0] x, input logic [5:0] n,
                                                  input logic cin, input logic [5:0] ij);
      logic b;
      logic [5:0] bo;
      b = cin;
      bo = 6'h00;
      for (int i = 0; i < 6; i++) begin
         b = b | ij[i];
         bo[i] = (~x[i] & n[i]) | (~(x[i] ^ n[i]) & b);
         b = bo[i];
      end
      return bo;
   endfunction

   // The addend is always complemented on its way in; no input gating.
   assign dn = ~d_q;
   assign half = x_q ^ dn;

   // Update controls; the control section keeps them off in plain arithmetic.
   assign force14 = (ctrl.upd_mode != sadd_pkg::UP_NONE);
   assign inhibit_ea = (ctrl.upd_mode == sadd_pkg::UP_CW) ||
                       (ctrl.upd_mode == sadd_pkg::UP_ADV);
   assign force_ea = (ctrl.upd_mode == sadd_pkg::UP_REP);
   assign inj = force14 ? sadd_pkg::FORCE_MASK : sadd_pkg::WORD_RST;

   // Four groups of six stages, each with its own generate and bypass enable.
   for (genvar g = 0; g < 4; g++) begin : g_grp
      logic [5:0] bo_free;
      logic [5:0] bo_live;
      logic [5:0] bin;
      assign bo_free = sadd_grp_borrow(x_q[g*6 +: 6], dn[g*6 +: 6], 1'b0, inj[g*6 +: 6]);
      assign grp_gen[g] = bo_free[5];
      // A group with all half-subtract bits zero neither needs nor satisfies a borrow.
      assign grp_byp_en[g] = (half[g*6 +: 6] == 6'h00) && (inj[g*6 +: 6] == 6'h00);
      assign grp_skip[g] = grp_byp_en[g] & grp_cin[g];
      assign bo_live = sadd_grp_borrow(x_q[g*6 +: 6], dn[g*6 +: 6], grp_cin[g],
                                       inj[g*6 +: 6]);
      assign bin = {bo_live[4:0], grp_cin[g]} | inj[g*6 +: 6];
      // A skipped group's zero difference becomes all ones.
      assign full[g*6 +: 6] = grp_skip[g] ? ~half[g*6 +: 6]
                                          : half[g*6 +: 6] ^ bin;
   end

   // Group borrow chain. Generate and enable do not depend on the carry in,
   // so the end-around term is solved in one pass with no combinational loop.
   always_comb begin
      end_borrow = grp_gen[3] | (grp_byp_en[3] & (grp_gen[2] | (grp_byp_en[2] &
                   (grp_gen[1] | (grp_byp_en[1] & grp_gen[0])))));
      if (inhibit_ea) begin
         grp_cin[0] = 1'b0;
      end else if (force_ea) begin
         grp_cin[0] = 1'b1;
      end else begin
         grp_cin[0] = end_borrow;
      end
      for (int g = 1; g < 4; g++) begin
         grp_cin[g] = grp_gen[g-1] | (grp_byp_en[g-1] & grp_cin[g-1]);
      end
   end

   // Operand register: memory word, accumulator, counter, index or base.
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         x_q <= sadd_pkg::WORD_RST;
      end else begin
         case (ctrl.x_sel)
            sadd_pkg::XS_MEM: x_q <= src.mem_word;
            sadd_pkg::XS_ACC: x_q <= a_q;
            sadd_pkg::XS_PC: x_q <= {10'h000, pc_q};
            sadd_pkg::XS_IDX: x_q <= src.idx_word & sadd_pkg::LOW14_MASK;
            sadd_pkg::XS_BASE: x_q <= {10'h000, src.base_word};
            default: x_q <= x_q;
         endcase
      end
   end

   // Addend register: transfers, complements and control constants.
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         d_q <= sadd_pkg::WORD_RST;
      end else begin
         case (ctrl.d_sel)
            sadd_pkg::DS_X: d_q <= x_q;
            sadd_pkg::DS_XN: d_q <= ~x_q;
            sadd_pkg::DS_ACCN: d_q <= ~a_q;
            sadd_pkg::DS_X9: d_q <= x_q & sadd_pkg::ADDR9_MASK;
            sadd_pkg::DS_P1: d_q <= sadd_pkg::PLUS_ONE;
            sadd_pkg::DS_P2: d_q <= sadd_pkg::PLUS_TWO;
            sadd_pkg::DS_UPD: d_q <= sadd_pkg::UPD_ADDEND;
            default: d_q <= d_q;
         endcase
      end
   end

   // Accumulator: logical or algebraic difference, or the lower rank back.
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         a_q <= sadd_pkg::WORD_RST;
      end else begin
         case (ctrl.a_sel)
            sadd_pkg::AS_CLR: a_q <= sadd_pkg::WORD_RST;
            sadd_pkg::AS_LOG: a_q <= half;
            sadd_pkg::AS_ALG: a_q <= full;
            sadd_pkg::AS_U: a_q <= u_q;
            default: a_q <= a_q;
         endcase
      end
   end

   // Lower rank takes the shifted accumulator; it costs a cycle per shift,
   // but the accumulator never has to shift itself in place.
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         u_q <= sadd_pkg::WORD_RST;
      end else begin
         case (ctrl.u_sel)
            sadd_pkg::US_SHL: u_q <= {a_q[22:0], src.shift_in};
            sadd_pkg::US_SHR: u_q <= {src.shift_in, a_q[23:1]};
            default: u_q <= u_q;
         endcase
      end
   end

   // Program counter takes the low address bits of the sum.
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         pc_q <= sadd_pkg::PC_RST;
      end else if (ctrl.pc_load) begin
         pc_q <= full[13:0];
      end
   end

   // Selector word carries sums back toward memory.
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         sel_q <= sadd_pkg::WORD_RST;
      end else if (ctrl.sel_load) begin
         sel_q <= full;
      end
   end

   assign acc_word = a_q;
   assign low_rank_word = u_q;
   assign pc_word = pc_q;
   assign sel_word = sel_q;
   // The control section uses this to skip updates of an exhausted tally.
   assign tally_zero = (x_q[23:14] == 10'h000);

   // Checking helpers.
   logic [23:0] chk_sum;
   logic [23:0] chk_adv;
   logic [23:0] chk_rep;
   logic [23:0] chk_shl;
   logic [24:0] chk_diff;
   logic [23:0] chk_oc;
   assign chk_sum = x_q + d_q;
   assign chk_adv = {x_q[23:14] - 10'h001, x_q[13:0] + 14'h0001};
   assign chk_rep = {x_q[23:14] - 10'h001, x_q[13:0]};
   assign chk_shl = {a_q[22:0], src.shift_in};
   // Plain 25-bit arithmetic models the adder apart from its borrow network:
   // a borrow out of the top stage comes back as one taken from the bottom.
   assign chk_diff = {1'b0, x_q} - {1'b0, ~d_q};
   assign chk_oc = chk_diff[24] ? chk_diff[23:0] - 24'h000001 : chk_diff[23:0];

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!reset_n);

   property p_sum_pos;
      (ctrl.upd_mode == sadd_pkg::UP_NONE) && !x_q[23] && !d_q[23] |-> full == chk_sum;
   endproperty
   a_sum_pos: assert property (p_sum_pos) else $error("Adder sum of positives wrong.");

   property p_acc_logical;
      ctrl.a_sel == sadd_pkg::AS_LOG |=> a_q == $past(x_q ^ ~d_q);
   endproperty
   a_acc_logical: assert property (p_acc_logical) else $error("Logical load wrong.");

   property p_acc_alg;
      ctrl.a_sel == sadd_pkg::AS_ALG |=> a_q == $past(full);
   endproperty
   a_acc_alg: assert property (p_acc_alg) else $error("Algebraic load wrong.");

   property p_shift;
      (ctrl.u_sel == sadd_pkg::US_SHL) ##1
      (ctrl.a_sel == sadd_pkg::AS_U && ctrl.u_sel == sadd_pkg::US_HOLD)
      |=> a_q == $past(chk_shl, 2);
   endproperty
   a_shift: assert property (p_shift) else $error("Shift through lower rank wrong.");

   property p_advance;
      (ctrl.upd_mode inside {sadd_pkg::UP_CW, sadd_pkg::UP_ADV}) &&
      (d_q == sadd_pkg::UPD_ADDEND) && !tally_zero |-> full == chk_adv;
   endproperty
   a_advance: assert property (p_advance) else $error("Count update wrong.");

   property p_repeat;
      (ctrl.upd_mode == sadd_pkg::UP_REP) && (d_q == sadd_pkg::UPD_ADDEND) &&
      !tally_zero |-> full == chk_rep;
   endproperty
   a_repeat: assert property (p_repeat) else $error("Repeat update wrong.");

   property p_upd_addend;
      ctrl.d_sel == sadd_pkg::DS_UPD |=> d_q[23:14] == 10'h3FF && d_q[13:0] == 14'h0000;
   endproperty
   a_upd_addend: assert property (p_upd_addend) else $error("Addend not forced.");

   property p_pc_step;
      (ctrl.x_sel == sadd_pkg::XS_PC && ctrl.d_sel == sadd_pkg::DS_P1 && !ctrl.pc_load)
      ##1 (ctrl.pc_load && ctrl.upd_mode == sadd_pkg::UP_NONE)
      |=> pc_q == $past(pc_q, 2) + 14'h0001;
   endproperty
   a_pc_step: assert property (p_pc_step) else $error("Counter advance wrong.");

   property p_sel;
      ctrl.sel_load |=> sel_q == $past(full);
   endproperty
   a_sel: assert property (p_sel) else $error("Selector word wrong.");

   property p_hold;
      ctrl.x_sel == sadd_pkg::XS_HOLD && ctrl.d_sel == sadd_pkg::DS_HOLD
      |=> $stable(x_q) && $stable(d_q);
   endproperty
   a_hold: assert property (p_hold) else $error("Register changed without enable.");

   property p_skip;
      grp_skip[1] |-> full[11:6] == 6'h3F;
   endproperty
   a_skip: assert property (p_skip) else $error("Skipped group not all ones.");

   // The tally drops by one even when the address bits alone would not borrow.
   property p_force;
      (ctrl.upd_mode != sadd_pkg::UP_NONE) && (d_q == sadd_pkg::UPD_ADDEND) && !tally_zero
      |-> full[23:14] == x_q[23:14] - 10'h001;
   endproperty
   a_force: assert property (p_force) else $error("Update borrows wrong.");

   // Every ordinary pass must match one's complement arithmetic, group skips included.
   property p_oc_sum;
      ctrl.upd_mode == sadd_pkg::UP_NONE |-> full == chk_oc;
   endproperty
   a_oc_sum: assert property (p_oc_sum) else $error("Adder result wrong.");

   // Right shifts fill from the shift input at the top.
   property p_shr;
      ctrl.u_sel == sadd_pkg::US_SHR |=> u_q == $past({src.shift_in, a_q[23:1]});
   endproperty
   a_shr: assert property (p_shr) else $error("Right shift into lower rank wrong.");

   // Only the low index bits reach the operand register.
   property p_idx_low;
      ctrl.x_sel == sadd_pkg::XS_IDX
      |=> x_q[23:14] == 10'h000 && x_q[13:0] == $past(src.idx_word[13:0]);
   endproperty
   a_idx_low: assert property (p_idx_low) else $error("Index load wrong.");

   // Base modification takes only nine address bits into the addend.
   property p_base_addend;
      ctrl.d_sel == sadd_pkg::DS_X9 |=> d_q[23:9] == 15'h0000 && d_q[8:0] == $past(x_q[8:0]);
   endproperty
   a_base_addend: assert property (p_base_addend) else $error("Base addend wrong.");

   // The two-word advance follows the same path with the addend set to two.
   property p_pc_two;
      (ctrl.x_sel == sadd_pkg::XS_PC && ctrl.d_sel == sadd_pkg::DS_P2 && !ctrl.pc_load)
      ##1 (ctrl.pc_load && ctrl.upd_mode == sadd_pkg::UP_NONE)
      |=> pc_q == $past(pc_q, 2) + 14'h0002;
   endproperty
   a_pc_two: assert property (p_pc_two) else $error("Counter double advance wrong.");

   // Clearing the accumulator gives plus zero, never the all-ones minus zero.
   property p_clear;
      ctrl.a_sel == sadd_pkg::AS_CLR |=> a_q == sadd_pkg::WORD_RST;
   endproperty
   a_clear: assert property (p_clear) else $error("Accumulator not cleared.");

   c_adv: cover property (ctrl.upd_mode == sadd_pkg::UP_ADV && !tally_zero);
   c_rep: cover property (ctrl.upd_mode == sadd_pkg::UP_REP && !tally_zero);
   c_wrap: cover property (ctrl.upd_mode == sadd_pkg::UP_NONE && end_borrow);
   c_skip: cover property (|grp_skip);
   c_shift: cover property (ctrl.u_sel == sadd_pkg::US_SHL ##1 ctrl.a_sel == sadd_pkg::AS_U);

endmodule

/* File: sim/sadd_ctl_model.sv */
// Control section model: sequences the datapath register loads the way the
// instruction sequencer does. Assumes the bench calls its tasks at negedges.
`timescale 1ns/1ps

module sadd_ctl_model (
   // Clock.
   input wire logic sys_clk,
   // Selects and source words toward the datapath.
   output sadd_pkg::sadd_ctrl_t ctrl,
   output sadd_pkg::sadd_src_t src
);
   initial begin
      ctrl = '0;
      src = '0;
   end

   // One select word per cycle; it changes only at the falling edge.
   task automatic cmd(input logic [2:0] x, d, a, input logic [1:0] u, m, input logic p, s);
      @(negedge sys_clk);
      ctrl = {x, d, a, u, m, p, s};
   endtask

   // Idle; the memory word is no longer held, so it shows garbage.
   task automatic idle;
      cmd(0, 0, 0, 0, 0, 0, 0);
      src.mem_word = ~src.mem_word;
   endtask

   // Addend from a, operand b, then accumulator load of kind as.
   task automatic alu(input logic [23:0] a, b, input logic [2:0] as);
      cmd(1, 0, 0, 0, 0, 0, 0);
      src.mem_word = a;
      cmd(0, 1, 0, 0, 0, 0, 0);
      cmd(1, 0, 0, 0, 0, 0, 0);
      src.mem_word = b;
      cmd(0, 0, as, 0, 0, 0, 0);
      idle();
   endtask

   // Shift through the lower rank, then copy back.
   task automatic shift(input logic left, si);
      cmd(0, 0, 0, left ? 2'h1 : 2'h2, 0, 0, 0);
      src.shift_in = si;
      cmd(0, 0, 4, 0, 0, 0, 0);
      idle();
   endtask

   // Accumulator minus a memory word: the word reaches the addend complemented.
   task automatic sub(input logic [23:0] w);
      cmd(1, 0, 0, 0, 0, 0, 0);
      src.mem_word = w;
      cmd(2, 2, 0, 0, 0, 0, 0);
      cmd(0, 0, 3, 0, 0, 0, 0);
      idle();
   endtask

   // Negate the accumulator: complement into the addend, clear, then add back.
   task automatic negate;
      cmd(0, 3, 1, 0, 0, 0, 0);
      cmd(2, 0, 0, 0, 0, 0, 0);
      cmd(0, 0, 3, 0, 0, 0, 0);
      idle();
   endtask

   // Program counter through the operand register plus one or two.
   task automatic pc_adv(input logic two);
      cmd(3, two ? 3'h6 : 3'h5, 0, 0, 0, 0, 0);
      cmd(0, 0, 0, 0, 0, 1, 0);
      idle();
   endtask

   // Word update; the borrow controls are raised in this cycle only.
   task automatic upd(input logic [1:0] m, input logic [23:0] w);
      cmd(1, 7, 0, 0, 0, 0, 0);
      src.mem_word = w;
      cmd(0, 0, 0, 0, m, 0, 1);
      idle();
   endtask

   // Address modification by index word or base register.
   task automatic amod(input logic b, input logic [23:0] ad, ix, input logic [13:0] bs);
      cmd(1, 0, 0, 0, 0, 0, 0);
      src.mem_word = ad;
      cmd(0, b ? 3'h4 : 3'h1, 0, 0, 0, 0, 0);
      cmd(b ? 3'h5 : 3'h4, 0, 0, 0, 0, 0, 0);
      src.idx_word = ix;
      src.base_word = bs;
      cmd(0, 0, 0, 0, 0, 0, 1);
      idle();
   endtask

   // Add one to a memory word, result toward the selector.
   task automatic add_one(input logic [23:0] w);
      cmd(1, 5, 0, 0, 0, 0, 0);
      src.mem_word = w;
      cmd(0, 0, 0, 0, 0, 0, 1);
      idle();
   endtask
endmodule

/* File: sim/sadd_datapath_test.sv */
// Self-checking bench for the subtractive adder datapath.
// Assumes sadd_ctl_model drives every select; expectations come from functions.
`timescale 1ns/1ps

module sadd_datapath_test;
   logic sys_clk = 1'b0;
   logic reset_n = 1'b0;
   sadd_pkg::sadd_ctrl_t ctrl;
   sadd_pkg::sadd_src_t src;
   logic [23:0] acc_word, low_rank_word, sel_word, r, a, b, e;
   logic [13:0] pc_word, pc_e;
   logic tally_zero;
   int num_errors = 0;
   int n_tests = 0;
   logic [23:0] ca [4] = '{24'h000001, 24'hFFFFFF, 24'h000001, 24'h800000};
   logic [23:0] cb [4] = '{24'hFFFFFE, 24'hFFFFFF, 24'h03FFFF, 24'h800000};

   // Free-running 25 MHz clock.
   always #20 sys_clk = ~sys_clk;

   sadd_ctl_model ctl (.sys_clk(sys_clk), .ctrl(ctrl), .src(src));
   sadd_datapath dut (.sys_clk(sys_clk), .reset_n(reset_n), .ctrl(ctrl), .src(src),
      .acc_word(acc_word), .low_rank_word(low_rank_word), .pc_word(pc_word),
      .sel_word(sel_word), .tally_zero(tally_zero));

   // Pseudo-random source; the tap set is arbitrary but fixed.
   function automatic logic [23:0] nxt(input logic [23:0] v);
      return {v[22:0], v[23] ^ v[22] ^ v[21] ^ v[16]};
   endfunction

   // Subtractive sum: operand minus complemented addend, end-around borrow.
   function automatic logic [23:0] fsum(input logic [23:0] x, d);
      logic [24:0] t;
      t = {1'b0, x} - {1'b0, ~d};
      return t[24] ? t[23:0] - 24'h000001 : t[23:0];
   endfunction

   // Updated word: tally down, address up unless repeating.
   function automatic logic [23:0] fupd(input logic [1:0] m, input logic [23:0] w);
      return {w[23:14] - 10'h001, (m == 2'h3) ? w[13:0] : w[13:0] + 14'h0001};
   endfunction

   task automatic chk(input logic [23:0] g, x);
      n_tests++;
      if (g !== x) begin
         num_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
      end
   endtask

   task automatic chk_flag(input logic g, x);
      n_tests++;
      if (g !== x) begin
         num_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
      end
   endtask

   task automatic summarize;
      $display("tests=%0d mismatches=%0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // Watchdog sized well beyond the few hundred cycles the tests need.
   initial begin
      #(40 * 20000);
      num_errors++;
      summarize();
   end

   initial begin
      r = 24'h000039;
      repeat (20) @(negedge sys_clk);
      reset_n = 1'b1;
      chk(acc_word, 24'h000000);
      chk_flag(tally_zero, 1'b1);
      $display("test reset done");
      // Corner pairs first (zero, minus zero, group ripple, end-around).
      for (int i = 0; i < 16; i++) begin
         r = nxt(r);
         a = (i < 4) ? ca[i] : r;
         r = nxt(r);
         b = (i < 4) ? cb[i] : r;
         ctl.alu(a, b, 3);
         chk(acc_word, fsum(b, a));
         ctl.alu(a, b, 2);
         chk(acc_word, b ^ ~a);
         e = i[0] ? {acc_word[22:0], r[5]} : {r[5], acc_word[23:1]};
         ctl.shift(i[0], r[5]);
         chk(low_rank_word, e);
         chk(acc_word, e);
         e = fsum(acc_word, ~b);
         ctl.sub(b);
         chk(acc_word, e);
         e = fsum(24'h000000, ~e);
         ctl.negate();
         chk(acc_word, e);
      end
      $display("test arith done");
      pc_e = 14'h0000;
      for (int i = 0; i < 6; i++) begin
         ctl.pc_adv(i[0]);
         pc_e = pc_e + (i[0] ? 14'h0002 : 14'h0001);
         chk({10'h000, pc_word}, {10'h000, pc_e});
         chk_flag(tally_zero, 1'b1);
      end
      $display("test pc done");
      for (int i = 0; i < 12; i++) begin
         r = nxt(r);
         e = {(r[23:14] == 10'h000) ? 10'h001 : r[23:14], (i < 3) ? 14'h3FFF : {1'b0, r[12:0]}};
         ctl.upd(2'(i % 3 + 1), e);
         chk(sel_word, fupd(2'(i % 3 + 1), e));
         chk_flag(tally_zero, 1'b0);
      end
      $display("test update done");
      for (int i = 0; i < 8; i++) begin
         r = nxt(r);
         a = r & 24'h003FFF;
         r = nxt(r);
         e = i[0] ? fsum({10'h000, r[13:0]}, a & 24'h0001FF) : fsum(r & 24'h003FFF, a);
         ctl.amod(i[0], a, r, r[13:0]);
         chk(sel_word, e);
      end
      $display("test modify done");
      for (int i = 0; i < 6; i++) begin
         r = nxt(r);
         a = (i == 0) ? 24'hFFFFFE : (i == 1) ? 24'hFFFFFF : r;
         ctl.add_one(a);
         chk(sel_word, fsum(a, 24'h000001));
      end
      $display("test add one done");
      summarize();
   end
endmodule
